// ===== sim/cim_cpu_model.sv
// cpu side of the two interrupt lines: counts each assertion
// assumes the lines are registered levels on clk_sys
`timescale 1ns/1ps
module cim_cpu_model (
   input  wire logic        clk_sys,   // module clock
   input  wire logic        srst,      // sync reset, high
   input  wire logic        irq_line0, // interrupt line 0
   input  wire logic        irq_line1, // interrupt line 1
   output logic      [15:0] rise0,     // assertions seen on line 0
   output logic      [15:0] rise1      // assertions seen on line 1
);
   logic [1:0] prev_r; // last sampled line levels

   // a level cpu input sees each new assertion once
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prev_r <= 2'h0;
         rise0  <= 16'h0000;
         rise1  <= 16'h0000;
      end else begin
         prev_r <= {irq_line1, irq_line0};
         if (irq_line0 && !prev_r[0]) rise0 <= rise0 + 16'h0001;
         if (irq_line1 && !prev_r[1]) rise1 <= rise1 + 16'h0001;
      end
   end
endmodule

// ===== sim/tb.sv
// self-checking bench for the interrupt enable and line routing stage
// assumes one 125 mhz clock and a register master that never waits
`timescale 1ns/1ps
module tb;
   import cim_pkg::*;
   logic        clk_sys   = 1'b0;          // module clock
   logic        srst      = 1'b1;          // sync reset
   logic [7:0]  reg_addr  = 8'h00;         // register address
   logic [31:0] reg_wdata = 32'h0000_0000; // write data
   logic        reg_wr    = 1'b0;          // write strobe
   logic        reg_rd    = 1'b0;          // read strobe
   logic [31:0] flag_cond = 32'h0000_0000; // condition levels
   logic [31:0] reg_rdata;                 // read data
   logic [31:0] flags_out;                 // sticky flags
   logic        irq_line0;                 // line 0
   logic        irq_line1;                 // line 1
   logic [15:0] rise0;                     // line 0 assertions
   logic [15:0] rise1;                     // line 1 assertions
   int          num_errors      = 0;       // mismatches
   int          samples_checked = 0;       // comparisons
   int          cycles          = 0;       // timeout counter

   cim_irq_route dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .flag_cond(flag_cond), .flags_out(flags_out),
      .irq_line0(irq_line0), .irq_line1(irq_line1));
   cim_cpu_model cpu (.clk_sys(clk_sys), .srst(srst), .irq_line0(irq_line0),
      .irq_line1(irq_line1), .rise0(rise0), .rise1(rise1));

   // 8 ns period
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // a hang is cut short well past the expected run length
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         end_sim;
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe, then fall to zero
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge clk_sys);
      #1 chk(reg_rdata, 32'h0000_0000);
   endtask

   // one-cycle condition pulse; the flag shows one edge later
   task automatic pulse(input logic [31:0] m);
      @(posedge clk_sys);
      flag_cond <= m;
      @(posedge clk_sys);
      flag_cond <= 32'h0000_0000;
      #1;
   endtask

   // line output lags a stored change by one registered stage
   task automatic settle;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   task automatic t_regs;
      rd_chk(CIM_OFF_FLAGS, CIM_RST_WORD);
      rd_chk(CIM_OFF_IE, CIM_RST_WORD);
      rd_chk(CIM_OFF_ILS, CIM_RST_WORD);
      rd_chk(CIM_OFF_ILE, 32'h0000_0000);
      wr(CIM_OFF_IE, 32'hFFFF_FFFF);
      wr(CIM_OFF_ILS, 32'hA5A5_5A5A);
      wr(CIM_OFF_ILE, 32'hFFFF_FFFF);
      wr(8'h60, 32'h1234_5678);
      rd_chk(CIM_OFF_IE, 32'hFFFF_FFFF);
      rd_chk(CIM_OFF_ILS, 32'hA5A5_5A5A);
      rd_chk(CIM_OFF_ILE, 32'h0000_0003);
      rd_chk(8'h60, 32'h0000_0000);
   endtask

   // each flag alone: masked, then enabled onto its selected line
   task automatic t_each_flag;
      logic [31:0] m;
      wr(CIM_OFF_ILS, 32'hAAAA_AAAA);
      for (int i = 0; i < 32; i++) begin
         m = 32'h0000_0001 << i;
         wr(CIM_OFF_IE, ~m);
         pulse(m);
         chk(flags_out, m);
         settle;
         chk({30'h0, irq_line1, irq_line0}, 32'h0000_0000);
         wr(CIM_OFF_IE, m);
         settle;
         chk({irq_line1, irq_line0}, i[0] ? 2'h2 : 2'h1);
         chk({irq_line1, irq_line0}, i[0] ? 2'h2 : 2'h1);
         chk({irq_line1, irq_line0}, i[0] ? 2'h2 : 2'h1);
         wr(CIM_OFF_FLAGS, ~m);
         settle;
         chk(flags_out, m);
         wr(CIM_OFF_FLAGS, m);
         settle;
         chk(flags_out, 32'h0000_0000);
         chk({30'h0, irq_line1, irq_line0}, 32'h0000_0000);
      end
      chk({rise1, rise0}, {16'h0010, 16'h0010});
   endtask

   // per-line enables hold a line low while its flags stay set
   task automatic t_line_en;
      wr(CIM_OFF_ILS, 32'h0000_0002);
      wr(CIM_OFF_IE, 32'h0000_0003);
      pulse(32'h0000_0003);
      wr(CIM_OFF_ILE, 32'h0000_0001);
      settle;
      chk({irq_line1, irq_line0}, 2'h1);
      wr(CIM_OFF_ILE, 32'h0000_0002);
      settle;
      chk({irq_line1, irq_line0}, 2'h2);
      wr(CIM_OFF_ILE, 32'h0000_0000);
      settle;
      chk({irq_line1, irq_line0}, 2'h0);
   endtask

   // a clear landing with a new set edge leaves the flag set
   task automatic t_set_wins;
      wr(CIM_OFF_FLAGS, 32'hFFFF_FFFF);
      @(posedge clk_sys);
      flag_cond <= 32'h0000_0004;
      reg_wr    <= 1'b1;
      reg_addr  <= CIM_OFF_FLAGS;
      reg_wdata <= 32'h0000_0004;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      flag_cond <= 32'h0000_0000;
      settle;
      chk(flags_out, 32'h0000_0004);
      rd_chk(CIM_OFF_FLAGS, 32'h0000_0004);
   endtask

   // a hard reset in mid-run empties set flags, the mask and the lines
   task automatic t_reset;
      wr(CIM_OFF_ILS, 32'h0000_0000);
      wr(CIM_OFF_IE, 32'hFFFF_FFFF);
      wr(CIM_OFF_ILE, 32'h0000_0003);
      settle;
      chk({30'h0, irq_line1, irq_line0}, 32'h0000_0001);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      #1;
      chk(flags_out, CIM_RST_WORD);
      chk({30'h0, irq_line1, irq_line0}, 32'h0000_0000);
      rd_chk(CIM_OFF_IE, CIM_RST_WORD);
      rd_chk(CIM_OFF_ILE, 32'h0000_0000);
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      t_regs;
      t_each_flag;
      t_line_en;
      t_set_wins;
      t_reset;
      end_sim;
   end
endmodule

// ===== src/cim_flag_bank.sv
// sticky interrupt flags, set on a rising condition, cleared by writing 1
// assumes condition inputs come from logic on clk_sys
`timescale 1ns/1ps
module cim_flag_bank
   import cim_pkg::*;
(
   input  wire logic                 clk_sys,    // module clock
   input  wire logic                 srst,       // sync reset, high
   input  wire logic [CIM_NFLAG-1:0] flag_cond,  // condition levels
   input  wire logic                 clr_stb,    // clear write strobe
   input  wire logic [CIM_NFLAG-1:0] clr_mask,   // ones clear flags
   output logic      [CIM_NFLAG-1:0] flags       // sticky flags
);
   logic [CIM_NFLAG-1:0] cond_prev_r;  // last cycle's conditions
   logic [CIM_NFLAG-1:0] flags_r;      // flag storage
   logic [CIM_NFLAG-1:0] set_evt;      // rising edges of conditions

   assign set_evt = flag_cond & ~cond_prev_r;
   assign flags   = flags_r;

   genvar gi;
   generate
      for (gi = 0; gi < CIM_NFLAG; gi++) begin : g_flag
         // w1c reset clear; set beats a clear in the same cycle
         always_ff @(posedge clk_sys) begin
            if (srst) begin
               flags_r[gi]     <= 1'b0;
               cond_prev_r[gi] <= 1'b0;
            end else begin
               cond_prev_r[gi] <= flag_cond[gi];
               if (set_evt[gi])
                  flags_r[gi] <= 1'b1;
               else if (clr_stb && clr_mask[gi])
                  flags_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule

// ===== src/cim_irq_route.sv
// interrupt enable mask and line routing stage of a can controller
// assumes a plain register port on clk_sys and condition levels
// from the protocol engine on the same clock
//
// Summary of operation
// - flag signals only when its enable is set
// - enable bits 0-4 gate protocol error flags
// - bits 6-8 gate bus state changes
// - bit 5 watchdog, bit 9 log overflow
// - bits 10, 11 gate ram bit errors
// - bit 12 dedicated buffer, 13 timeout
// - bit 14 ram failure, 15 timestamp wrap
// - bits 16-19 gate tx event queue
// - bits 20-22 gate tx queue flags
// - bit 23 gates high priority message
// - bits 24-27 gate rx queue 1
// - bits 28-31 gate rx queue 0
// - two lines, each flag picks one
// - select 0 line zero, 1 line one
// - select uses same bit positions
// - flags set on edge, stay set
// - write 1 clears, zeros ignored, reset clears
// - per-line enable holds line low
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module cim_irq_route
   import cim_pkg::*;
(
   input  wire logic                 clk_sys,    // 125 mhz module clock
   input  wire logic                 srst,       // sync reset, high
   input  wire logic [7:0]           reg_addr,   // byte address
   input  wire logic [31:0]          reg_wdata,  // write data
   input  wire logic                 reg_wr,     // write strobe
   input  wire logic                 reg_rd,     // read strobe
   output logic      [31:0]          reg_rdata,  // read data, next cycle
   input  wire logic [CIM_NFLAG-1:0] flag_cond,  // flag condition levels
   output logic      [CIM_NFLAG-1:0] flags_out,  // sticky flag state
   output logic                      irq_line0,  // interrupt line 0
   output logic                      irq_line1   // interrupt line 1
);
   // configuration registers
   logic [CIM_NFLAG-1:0] ie_r;       // interrupt_enable_mask
   logic [CIM_NFLAG-1:0] ie_nxt;
   logic [CIM_NFLAG-1:0] ils_r;      // interrupt_line_select
   logic [CIM_NFLAG-1:0] ils_nxt;
   logic [CIM_NLINE-1:0] ile_r;      // line_enables
   logic [CIM_NLINE-1:0] ile_nxt;
   logic [31:0]          rdata_r;    // read data register
   logic [31:0]          rdata_nxt;
   logic [CIM_NFLAG-1:0] flags;      // from the flag bank

   // address decode
   logic hit_flags;                  // flag register selected
   logic hit_ie;                     // enable mask selected
   logic hit_ils;                    // line select selected
   logic hit_ile;                    // line enables selected
   logic wr_flags;                   // clear write to flags
   logic wr_ie;                      // write to enable mask
   logic wr_ils;                     // write to line select
   logic wr_ile;                     // write to line enables
   logic [31:0] rd_mux;              // word chosen for a read

   assign hit_flags = (reg_addr == CIM_OFF_FLAGS);
   assign hit_ie    = (reg_addr == CIM_OFF_IE);
   assign hit_ils   = (reg_addr == CIM_OFF_ILS);
   assign hit_ile   = (reg_addr == CIM_OFF_ILE);
   assign wr_flags  = reg_wr & hit_flags;
   assign wr_ie     = reg_wr & hit_ie;
   assign wr_ils    = reg_wr & hit_ils;
   assign wr_ile    = reg_wr & hit_ile;

   // unmapped reads answer zero; upper bits of line enables read zero
   assign rd_mux = hit_flags ? flags :
                   hit_ie    ? ie_r  :
                   hit_ils   ? ils_r :
                   hit_ile   ? {{(32-CIM_NLINE){1'b0}}, ile_r} :
                               CIM_RST_WORD;

   // next values: full-word writes, no byte lanes on this port
   assign ie_nxt    = wr_ie  ? reg_wdata : ie_r;
   assign ils_nxt   = wr_ils ? reg_wdata : ils_r;
   assign ile_nxt   = wr_ile ? reg_wdata[CIM_NLINE-1:0] : ile_r;
   // data stands one cycle after the read strobe, zero otherwise
   assign rdata_nxt = reg_rd ? rd_mux : CIM_RST_WORD;

   assign reg_rdata = rdata_r;
   assign flags_out = flags;

   // mask reset zero
   // enable mask and line select storage
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ie_r  <= CIM_RST_WORD;
         ils_r <= CIM_RST_WORD;
         ile_r <= CIM_RST_ILE;
      end else begin
         ie_r  <= ie_nxt;
         ils_r <= ils_nxt;
         ile_r <= ile_nxt;
      end
   end

   // read data register
   always_ff @(posedge clk_sys) begin
      if (srst)
         rdata_r <= CIM_RST_WORD;
      else
         rdata_r <= rdata_nxt;
   end

   // clear by write
   // outside reset, flags are cleared only by ones in a write to the flag register
   cim_flag_bank u_flags (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .flag_cond (flag_cond),
      .clr_stb   (wr_flags),
      .clr_mask  (reg_wdata),
      .flags     (flags)
   );

   // two lines
   // one bit position per flag across flags, mask and select, so each
   // flag reaches exactly one line; a trade: no priority among flags
   cim_line_router u_route (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .flags     (flags),
      .ie_mask   (ie_r),
      .line_sel  (ils_r),
      .line_en   (ile_r),
      .irq_line0 (irq_line0),
      .irq_line1 (irq_line1)
   );

   // helper terms read only by the checks below
   logic [CIM_NFLAG-1:0] to0;        // gated flags aimed at line 0
   logic [CIM_NFLAG-1:0] to1;        // gated flags aimed at line 1
   logic                 cond0_prev_r; // stuff error condition, delayed
   assign to0 = flags & ie_r & ~ils_r;
   assign to1 = flags & ie_r & ils_r;

   // mask of flags lo to hi; groups the flags checked under one rule
   function automatic logic [CIM_NFLAG-1:0] cim_span(int lo, int hi);
      logic [CIM_NFLAG-1:0] m = CIM_RST_WORD;
      for (int b = lo; b <= hi; b++)
         m[b] = 1'b1;
      return m;
   endfunction
   // flag groups, each gated under one enable rule
   localparam logic [CIM_NFLAG-1:0] M_BUS_STATE =
      cim_span(CIM_B_BUSOFF, CIM_B_ERR_PASS);
   localparam logic [CIM_NFLAG-1:0] M_WDOG_LOG =
      (32'h0000_0001 << CIM_B_RAM_WDOG) | (32'h0000_0001 << CIM_B_LOG_OVF);
   localparam logic [CIM_NFLAG-1:0] M_RAM_BIT =
      cim_span(CIM_B_RAM_UNCORR, CIM_B_RAM_CORR);
   localparam logic [CIM_NFLAG-1:0] M_RXBUF_TMO =
      cim_span(CIM_B_DED_RXBUF, CIM_B_TIMEOUT);
   localparam logic [CIM_NFLAG-1:0] M_FAIL_WRAP =
      cim_span(CIM_B_RAM_FAIL, CIM_B_TS_WRAP);
   localparam logic [CIM_NFLAG-1:0] M_TX_EVENT =
      cim_span(CIM_B_TXE_LOST, CIM_B_TXE_NEW);
   localparam logic [CIM_NFLAG-1:0] M_TX_QUEUE =
      cim_span(CIM_B_TXQ_EMPTY, CIM_B_TX_DONE);
   localparam logic [CIM_NFLAG-1:0] M_HIGH_PRIO =
      cim_span(CIM_B_HIGH_PRIO, CIM_B_HIGH_PRIO);
   localparam logic [CIM_NFLAG-1:0] M_RX_QUEUE1 =
      cim_span(CIM_B_RXQ1_LOST, CIM_B_RXQ1_NEW);

   always_ff @(posedge clk_sys) begin
      if (srst)
         cond0_prev_r <= 1'b0;
      else
         cond0_prev_r <= flag_cond[CIM_B_STUFF_ERR];
   end

   // line 0 only rises for an enabled flag aimed at it
   property p_line0_cause;
      @(posedge clk_sys) disable iff (srst)
      irq_line0 |-> $past(|to0) && $past(ile_r[CIM_ILE_L0]);
   endproperty
   a_line0_cause: assert property (p_line0_cause)
      else $error("line 0 high without an enabled flag");

   // line 1 likewise
   property p_line1_cause;
      @(posedge clk_sys) disable iff (srst)
      irq_line1 |-> $past(|to1) && $past(ile_r[CIM_ILE_L1]);
   endproperty
   a_line1_cause: assert property (p_line1_cause)
      else $error("line 1 high without an enabled flag");

   // a rising stuff error condition reaches line 0 two cycles later
   property p_stuff_to_line0;
      @(posedge clk_sys) disable iff (srst)
      (flag_cond[CIM_B_STUFF_ERR] && !cond0_prev_r
       && ie_r[CIM_B_STUFF_ERR] && !ils_r[CIM_B_STUFF_ERR]
       && ile_r[CIM_ILE_L0] && !wr_ie && !wr_ils && !wr_ile)
      |-> ##2 irq_line0;
   endproperty
   a_stuff_to_line0: assert property (p_stuff_to_line0)
      else $error("enabled stuff error missed line 0");

   // a disabled line 0 stays low
   property p_line_off;
      @(posedge clk_sys) disable iff (srst)
      !ile_r[CIM_ILE_L0] |=> !irq_line0;
   endproperty
   a_line_off: assert property (p_line_off)
      else $error("disabled line 0 asserted");

   // a one written to a flag clears it unless an edge arrives
   property p_w1c;
      @(posedge clk_sys) disable iff (srst)
      (wr_flags && reg_wdata[CIM_B_BUSOFF]
       && !(flag_cond[CIM_B_BUSOFF] && !$past(flag_cond[CIM_B_BUSOFF])))
      |=> !flags[CIM_B_BUSOFF];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("written one did not clear the flag");

   // a flag holds while no clearing one is written
   property p_hold;
      @(posedge clk_sys) disable iff (srst)
      (flags[CIM_B_TS_WRAP] && !(wr_flags && reg_wdata[CIM_B_TS_WRAP]))
      |=> flags[CIM_B_TS_WRAP];
   endproperty
   a_hold: assert property (p_hold)
      else $error("flag dropped without a clear");

   // reset leaves the mask and flags empty
   property p_reset_clear;
      @(posedge clk_sys)
      srst |=> (ie_r == CIM_RST_WORD) && (flags == CIM_RST_WORD);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("mask or flags not zero after reset");

   // timestamp wrap selected to line 1 drives line 1
   property p_wrap_line1;
      @(posedge clk_sys) disable iff (srst)
      (flags[CIM_B_TS_WRAP] && ie_r[CIM_B_TS_WRAP]
       && ils_r[CIM_B_TS_WRAP] && ile_r[CIM_ILE_L1])
      |=> irq_line1;
   endproperty
   a_wrap_line1: assert property (p_wrap_line1)
      else $error("line select bit 15 not honoured");

   // rx queue 0 new message with mask clear never raises a line
   property p_masked_quiet;
      @(posedge clk_sys) disable iff (srst)
      (flags == (CIM_RST_WORD | (32'h0000_0001 << CIM_B_RXQ0_NEW))
       && !ie_r[CIM_B_RXQ0_NEW])
      |=> !irq_line0 && !irq_line1;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet)
      else $error("masked flag raised a line");

   // both lines follow the or of gated flags
   property p_or_form;
      @(posedge clk_sys) disable iff (srst)
      1'b1 |=> (irq_line0 == ($past(|to0) & $past(ile_r[CIM_ILE_L0])))
            && (irq_line1 == ($past(|to1) & $past(ile_r[CIM_ILE_L1])));
   endproperty
   a_or_form: assert property (p_or_form)
      else $error("line differs from gated or");

   // read data follows the line select one cycle after the strobe
   property p_read_ils;
      @(posedge clk_sys) disable iff (srst)
      (reg_rd && hit_ils) |=> reg_rdata == $past(ils_r);
   endproperty
   a_read_ils: assert property (p_read_ils)
      else $error("line select read back wrong");

   property p_bus_state_gate;
      @(posedge clk_sys) disable iff (srst)
      (|(to0 & M_BUS_STATE) && ile_r[CIM_ILE_L0] |=> irq_line0)
      and (|(to1 & M_BUS_STATE) && ile_r[CIM_ILE_L1] |=> irq_line1);
   endproperty
   a_bus_state_gate: assert property (p_bus_state_gate)
      else $error("bus state flag missed its line");

   property p_wdog_log_gate;
      @(posedge clk_sys) disable iff (srst)
      (|(to0 & M_WDOG_LOG) && ile_r[CIM_ILE_L0] |=> irq_line0)
      and (|(to1 & M_WDOG_LOG) && ile_r[CIM_ILE_L1] |=> irq_line1);
   endproperty
   a_wdog_log_gate: assert property (p_wdog_log_gate)
      else $error("watchdog or log flag missed its line");

   property p_ram_bit_gate;
      @(posedge clk_sys) disable iff (srst)
      (|(to0 & M_RAM_BIT) && ile_r[CIM_ILE_L0] |=> irq_line0)
      and (|(to1 & M_RAM_BIT) && ile_r[CIM_ILE_L1] |=> irq_line1);
   endproperty
   a_ram_bit_gate: assert property (p_ram_bit_gate)
      else $error("ram bit error flag missed its line");

   property p_rxbuf_tmo_gate;
      @(posedge clk_sys) disable iff (srst)
      (|(to0 & M_RXBUF_TMO) && ile_r[CIM_ILE_L0] |=> irq_line0)
      and (|(to1 & M_RXBUF_TMO) && ile_r[CIM_ILE_L1] |=> irq_line1);
   endproperty
   a_rxbuf_tmo_gate: assert property (p_rxbuf_tmo_gate)
      else $error("buffer or timeout flag missed its line");

   property p_fail_wrap_gate;
      @(posedge clk_sys) disable iff (srst)
      (|(to0 & M_FAIL_WRAP) && ile_r[CIM_ILE_L0] |=> irq_line0)
      and (|(to1 & M_FAIL_WRAP) && ile_r[CIM_ILE_L1] |=> irq_line1);
   endproperty
   a_fail_wrap_gate: assert property (p_fail_wrap_gate)
      else $error("access failure or wrap flag missed its line");

   property p_tx_event_gate;
      @(posedge clk_sys) disable iff (srst)
      (|(to0 & M_TX_EVENT) && ile_r[CIM_ILE_L0] |=> irq_line0)
      and (|(to1 & M_TX_EVENT) && ile_r[CIM_ILE_L1] |=> irq_line1);
   endproperty
   a_tx_event_gate: assert property (p_tx_event_gate)
      else $error("tx event flag missed its line");

   property p_tx_queue_gate;
      @(posedge clk_sys) disable iff (srst)
      (|(to0 & M_TX_QUEUE) && ile_r[CIM_ILE_L0] |=> irq_line0)
      and (|(to1 & M_TX_QUEUE) && ile_r[CIM_ILE_L1] |=> irq_line1);
   endproperty
   a_tx_queue_gate: assert property (p_tx_queue_gate)
      else $error("tx queue flag missed its line");

   property p_high_prio_gate;
      @(posedge clk_sys) disable iff (srst)
      (|(to0 & M_HIGH_PRIO) && ile_r[CIM_ILE_L0] |=> irq_line0)
      and (|(to1 & M_HIGH_PRIO) && ile_r[CIM_ILE_L1] |=> irq_line1);
   endproperty
   a_high_prio_gate: assert property (p_high_prio_gate)
      else $error("high priority flag missed its line");

   property p_rx_queue1_gate;
      @(posedge clk_sys) disable iff (srst)
      (|(to0 & M_RX_QUEUE1) && ile_r[CIM_ILE_L0] |=> irq_line0)
      and (|(to1 & M_RX_QUEUE1) && ile_r[CIM_ILE_L1] |=> irq_line1);
   endproperty
   a_rx_queue1_gate: assert property (p_rx_queue1_gate)
      else $error("rx queue 1 flag missed its line");

   // main scenarios
   c_line0: cover property (@(posedge clk_sys) disable iff (srst)
      !irq_line0 ##1 irq_line0);
   c_line1: cover property (@(posedge clk_sys) disable iff (srst)
      !irq_line1 ##1 irq_line1);
   c_clear: cover property (@(posedge clk_sys) disable iff (srst)
      irq_line0 ##1 wr_flags ##2 !irq_line0);
   c_set_beats_clear: cover property (@(posedge clk_sys)
      disable iff (srst)
      wr_flags && reg_wdata[CIM_B_STUFF_ERR]
      && flag_cond[CIM_B_STUFF_ERR] && !cond0_prev_r);
endmodule

// ===== src/cim_line_router.sv
// gates flags by the enable mask and routes them onto two lines
// assumes all inputs are registers on clk_sys
`timescale 1ns/1ps
module cim_line_router
   import cim_pkg::*;
(
   input  wire logic                 clk_sys,   // module clock
   input  wire logic                 srst,      // sync reset, high
   input  wire logic [CIM_NFLAG-1:0] flags,     // sticky flags
   input  wire logic [CIM_NFLAG-1:0] ie_mask,   // enable mask
   input  wire logic [CIM_NFLAG-1:0] line_sel,  // 0 line0, 1 line1
   input  wire logic [CIM_NLINE-1:0] line_en,   // per-line enables
   output logic                      irq_line0, // interrupt line 0
   output logic                      irq_line1  // interrupt line 1
);
   logic [CIM_NFLAG-1:0] gated;    // flags passing the mask
   logic                 any0;     // some flag routed to line 0
   logic                 any1;     // some flag routed to line 1
   logic                 line0_r;  // registered line 0
   logic                 line1_r;  // registered line 1

   assign gated = flags & ie_mask;
   assign any0  = |(gated & ~line_sel);
   assign any1  = |(gated & line_sel);
   assign irq_line0 = line0_r;
   assign irq_line1 = line1_r;

   // registered lines; line enables hold lines low
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         line0_r <= 1'b0;
         line1_r <= 1'b0;
      end else begin
         line0_r <= any0 & line_en[CIM_ILE_L0];
         line1_r <= any1 & line_en[CIM_ILE_L1];
      end
   end
endmodule

// ===== src/cim_pkg.sv
// package for the interrupt enable and line routing stage
// assumes a 32-bit register port and one module clock
package cim_pkg;
   // register byte offsets
   localparam logic [7:0] CIM_OFF_FLAGS  = 8'h50;
   localparam logic [7:0] CIM_OFF_IE     = 8'h54;
   localparam logic [7:0] CIM_OFF_ILS    = 8'h58;
   localparam logic [7:0] CIM_OFF_ILE    = 8'h5C;
   // widths and reset values
   localparam int          CIM_NFLAG     = 32;
   localparam int          CIM_NLINE     = 2;
   localparam logic [31:0] CIM_RST_WORD  = 32'h0000_0000;
   localparam logic [1:0]  CIM_RST_ILE   = 2'h0;
   // line enable field positions
   localparam int          CIM_ILE_L0    = 0;
   localparam int          CIM_ILE_L1    = 1;
   // flag positions in flags, enable mask and line select
   localparam int CIM_B_STUFF_ERR  = 0;
   localparam int CIM_B_FORM_ERR   = 1;
   localparam int CIM_B_ACK_ERR    = 2;
   localparam int CIM_B_BIT_ERR    = 3;
   localparam int CIM_B_CRC_ERR    = 4;
   localparam int CIM_B_RAM_WDOG   = 5;
   localparam int CIM_B_BUSOFF     = 6;
   localparam int CIM_B_WARNING    = 7;
   localparam int CIM_B_ERR_PASS   = 8;
   localparam int CIM_B_LOG_OVF    = 9;
   localparam int CIM_B_RAM_UNCORR = 10;
   localparam int CIM_B_RAM_CORR   = 11;
   localparam int CIM_B_DED_RXBUF  = 12;
   localparam int CIM_B_TIMEOUT    = 13;
   localparam int CIM_B_RAM_FAIL   = 14;
   localparam int CIM_B_TS_WRAP    = 15;
   localparam int CIM_B_TXE_LOST   = 16;
   localparam int CIM_B_TXE_NEW    = 19;
   localparam int CIM_B_TXQ_EMPTY  = 20;
   localparam int CIM_B_TX_DONE    = 22;
   localparam int CIM_B_HIGH_PRIO  = 23;
   localparam int CIM_B_RXQ1_LOST  = 24;
   localparam int CIM_B_RXQ1_NEW   = 27;
   localparam int CIM_B_RXQ0_LOST  = 28;
   localparam int CIM_B_RXQ0_NEW   = 31;
endpackage
